// File: design/byal_alu_top.sv
// Byte ALU with status flags, word add/subtract and a small I/O space.
// Assumes an AHB-Lite master on clk_in; evt_in pins are asynchronous.
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "byal_defines.svh"

// How it works
// - Register sum, optional carry, five flags
// - Register difference, optional borrow, five flags
// - Immediate difference, five flags, one clock
// - Immediate difference with borrow, one clock
// - Word sum over pair, two clocks
// - Word difference over pair, S flag
// - Conjunction updates zero, negative, overflow
// - Inclusive and exclusive disjunction, three flags
// - Mask bit set forces bits high
// - Mask bit clear uses FF minus mask
// - Writing one clears the error flag; the six flags load as written
// - Bit ops rewrite whole register
// - Bit ops reach addresses 00 to 1F
module byal_alu_top #(
  parameter int IO_DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [7:0] evt_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [5:0] flags_out,
  output logic busy_out
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (IO_DEPTH < `BYAL_IO_EVT + 1 || IO_DEPTH > 32) begin : g_bad_depth
    $error("IO_DEPTH must hold the event register and fit 32 entries");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic dp_valid_q;
  logic dp_write_q;
  logic [7:0] dp_addr_q;
  logic bus_wr;
  logic busy;
  logic wr_cmd;
  logic [15:0] opd_q;
  logic [7:0] ops_q;
  logic [5:0] flag_q;
  logic err_q;
  byal_pkg::byal_cmd_t cmd_q;
  logic [2:0] bit_q;
  logic [5:0] ioa_q;
  byal_pkg::byal_state_t state_q;
  logic c_lo_q;
  logic z_lo_q;
  logic [15:0] res_q;
  logic [7:0] io_q [IO_DEPTH];
  logic [7:0] io_rd;
  logic io_in_range;
  logic io_bit_ok;
  logic io_we;
  logic err_set;
  logic [7:0] evt_s1_q;
  logic [7:0] evt_s2_q;
  logic [5:0] upd_mask;
  logic [5:0] new_flags;

  byal_alu_if alu ();

  byal_alu_core u_core (
    .alu(alu)
  );

  function automatic logic is_word(input byal_pkg::byal_cmd_t c);
    return c == byal_pkg::BYAL_CMD_WADD || c == byal_pkg::BYAL_CMD_WSUB;
  endfunction

  function automatic logic is_io(input byal_pkg::byal_cmd_t c);
    return c == byal_pkg::BYAL_CMD_IOSET || c == byal_pkg::BYAL_CMD_IOCLR ||
           c == byal_pkg::BYAL_CMD_IOWR || c == byal_pkg::BYAL_CMD_IORD;
  endfunction

  function automatic logic is_bitop(input byal_pkg::byal_cmd_t c);
    return c == byal_pkg::BYAL_CMD_IOSET || c == byal_pkg::BYAL_CMD_IOCLR;
  endfunction

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q <= 8'h00;
    end else if (hready_in) begin
      dp_valid_q <= hsel_in & htrans_in[1];
      dp_write_q <= hwrite_in;
      dp_addr_q <= haddr_in[7:0];
    end
  end

  // Accesses wait out a running operation so operands never change under it
  assign busy = (state_q != byal_pkg::BYAL_ST_IDLE);
  assign hreadyout_out = !(dp_valid_q && busy);
  assign hresp_out = 1'b0;
  assign bus_wr = dp_valid_q && dp_write_q && hreadyout_out;
  assign wr_cmd = bus_wr && (dp_addr_q == `BYAL_OFS_CMD);
  assign busy_out = busy;
  assign flags_out = flag_q;

  always_comb begin
    case (dp_addr_q)
      `BYAL_OFS_OPD: hrdata_out = {16'h0000, opd_q};
      `BYAL_OFS_OPS: hrdata_out = {24'h00_0000, ops_q};
      `BYAL_OFS_CMD: hrdata_out = {10'h000, ioa_q, 5'h00, bit_q, 3'h0, cmd_q};
      `BYAL_OFS_RES: hrdata_out = {16'h0000, res_q};
      `BYAL_OFS_SREG: hrdata_out = {22'h00_0000, err_q, busy, 2'b00, flag_q};
      default: hrdata_out = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ops_q <= `BYAL_RST_BYTE;
      cmd_q <= byal_pkg::BYAL_CMD_ADD;
      bit_q <= 3'h0;
      ioa_q <= 6'h00;
    end else begin
      if (bus_wr && dp_addr_q == `BYAL_OFS_OPS) begin
        ops_q <= hwdata_in[7:0];
      end
      if (wr_cmd) begin
        cmd_q <= byal_pkg::byal_cmd_t'(hwdata_in[`BYAL_CMD_OP_LSB +: 5]);
        bit_q <= hwdata_in[`BYAL_CMD_BIT_LSB +: 3];
        ioa_q <= hwdata_in[`BYAL_CMD_IOA_LSB +: 6];
      end
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= byal_pkg::BYAL_ST_IDLE;
    end else begin
      case (state_q)
        byal_pkg::BYAL_ST_IDLE: begin
          if (wr_cmd) begin
            state_q <= byal_pkg::BYAL_ST_EXEC;
          end
        end
        byal_pkg::BYAL_ST_EXEC: begin
          state_q <= is_word(cmd_q) ? byal_pkg::BYAL_ST_WORD : byal_pkg::BYAL_ST_IDLE;
        end
        byal_pkg::BYAL_ST_WORD: state_q <= byal_pkg::BYAL_ST_IDLE;
        default: state_q <= byal_pkg::BYAL_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Operand steering
  // ----------------------------------------
  assign io_in_range = (32'(ioa_q) < IO_DEPTH);
  assign io_rd = io_in_range ? io_q[ioa_q[4:0]] : 8'h00;
  assign io_bit_ok = (ioa_q <= `BYAL_IO_BIT_MAX);

  always_comb begin
    alu.op = byal_pkg::BYAL_OP_OR;
    alu.a = opd_q[7:0];
    alu.b = ops_q;
    alu.cin = 1'b0;
    alu.zin = 1'b1;
    upd_mask = 6'h00;
    case (cmd_q)
      byal_pkg::BYAL_CMD_ADD, byal_pkg::BYAL_CMD_ADC: begin
        alu.op = byal_pkg::BYAL_OP_ADD;
        alu.cin = (cmd_q == byal_pkg::BYAL_CMD_ADC) & flag_q[`BYAL_SREG_C];
        upd_mask = `BYAL_UPD_ARITH;
      end
      byal_pkg::BYAL_CMD_SUB, byal_pkg::BYAL_CMD_SUBK: begin
        alu.op = byal_pkg::BYAL_OP_SUB;
        upd_mask = `BYAL_UPD_ARITH;
      end
      byal_pkg::BYAL_CMD_SBCR, byal_pkg::BYAL_CMD_SBCK: begin
        alu.op = byal_pkg::BYAL_OP_SUB;
        alu.cin = flag_q[`BYAL_SREG_C];
        alu.zin = flag_q[`BYAL_SREG_Z];
        upd_mask = `BYAL_UPD_ARITH;
      end
      byal_pkg::BYAL_CMD_WADD, byal_pkg::BYAL_CMD_WSUB: begin
        alu.op = (cmd_q == byal_pkg::BYAL_CMD_WADD) ? byal_pkg::BYAL_OP_ADD : byal_pkg::BYAL_OP_SUB;
        if (state_q == byal_pkg::BYAL_ST_WORD) begin
          alu.a = opd_q[15:8];
          alu.b = 8'h00;
          alu.cin = c_lo_q;
          alu.zin = z_lo_q;
          upd_mask = `BYAL_UPD_WORD;
        end
      end
      byal_pkg::BYAL_CMD_AND, byal_pkg::BYAL_CMD_ANDK: begin
        alu.op = byal_pkg::BYAL_OP_AND;
        upd_mask = `BYAL_UPD_LOGIC;
      end
      byal_pkg::BYAL_CMD_OR, byal_pkg::BYAL_CMD_ORK, byal_pkg::BYAL_CMD_BSET: begin
        upd_mask = `BYAL_UPD_LOGIC;
      end
      byal_pkg::BYAL_CMD_XOR: begin
        alu.op = byal_pkg::BYAL_OP_XOR;
        upd_mask = `BYAL_UPD_LOGIC;
      end
      byal_pkg::BYAL_CMD_BCLR: begin
        alu.op = byal_pkg::BYAL_OP_AND;
        alu.b = 8'hFF - ops_q;
        upd_mask = `BYAL_UPD_LOGIC;
      end
      byal_pkg::BYAL_CMD_ONES: begin
        alu.op = byal_pkg::BYAL_OP_ONES;
        upd_mask = `BYAL_UPD_ONES;
      end
      byal_pkg::BYAL_CMD_TWOS: begin
        alu.op = byal_pkg::BYAL_OP_TWOS;
        upd_mask = `BYAL_UPD_ARITH;
      end
      byal_pkg::BYAL_CMD_IOSET: begin
        alu.a = io_rd;
        alu.b = 8'h01 << bit_q;
      end
      byal_pkg::BYAL_CMD_IOCLR: begin
        alu.op = byal_pkg::BYAL_OP_AND;
        alu.a = io_rd;
        alu.b = ~(8'h01 << bit_q);
      end
      byal_pkg::BYAL_CMD_IOWR: alu.a = 8'h00;
      byal_pkg::BYAL_CMD_IORD: begin
        alu.a = io_rd;
        alu.b = 8'h00;
      end
      default: upd_mask = 6'h00;
    endcase
  end

  // ----------------------------------------
  // Results and flags
  // ----------------------------------------
  assign new_flags = {alu.h, alu.n ^ alu.v, alu.v, alu.n, alu.z, alu.c};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_q <= 6'h00;
    end else if (state_q != byal_pkg::BYAL_ST_IDLE) begin
      flag_q <= (flag_q & ~upd_mask) | (new_flags & upd_mask);
    end else if (bus_wr && dp_addr_q == `BYAL_OFS_SREG) begin
      flag_q <= hwdata_in[5:0];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      opd_q <= `BYAL_RST_WORD;
    end else if (bus_wr && dp_addr_q == `BYAL_OFS_OPD) begin
      opd_q <= hwdata_in[15:0];
    end else if (state_q == byal_pkg::BYAL_ST_EXEC && !is_io(cmd_q)) begin
      opd_q[7:0] <= alu.res;
    end else if (state_q == byal_pkg::BYAL_ST_WORD) begin
      opd_q[15:8] <= alu.res;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      res_q <= `BYAL_RST_WORD;
      c_lo_q <= 1'b0;
      z_lo_q <= 1'b0;
    end else if (state_q == byal_pkg::BYAL_ST_EXEC) begin
      res_q <= {8'h00, alu.res};
      c_lo_q <= alu.c;
      z_lo_q <= alu.z;
    end else if (state_q == byal_pkg::BYAL_ST_WORD) begin
      res_q[15:8] <= alu.res;
    end
  end

  // Set wins over a software clear in the same cycle
  assign err_set = (state_q == byal_pkg::BYAL_ST_EXEC) && is_bitop(cmd_q) && !io_bit_ok;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      err_q <= 1'b0;
    end else begin
      err_q <= (err_q & ~(bus_wr && dp_addr_q == `BYAL_OFS_SREG && hwdata_in[`BYAL_SREG_ERR])) | err_set;
    end
  end

  // ----------------------------------------
  // I/O space
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      evt_s1_q <= `BYAL_RST_BYTE;
      evt_s2_q <= `BYAL_RST_BYTE;
    end else begin
      evt_s1_q <= evt_in;
      evt_s2_q <= evt_s1_q;
    end
  end

  // Out-of-range bit ops leave the space untouched
  assign io_we = (state_q == byal_pkg::BYAL_ST_EXEC) && is_io(cmd_q) && io_in_range &&
                 (cmd_q != byal_pkg::BYAL_CMD_IORD) && (!is_bitop(cmd_q) || io_bit_ok);

  for (genvar i = 0; i < IO_DEPTH; i++) begin : g_io
    if (i == `BYAL_IO_EVT) begin : g_evt
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          io_q[i] <= `BYAL_RST_BYTE;
        end else begin
          io_q[i] <= (io_q[i] & ~((io_we && ioa_q[4:0] == 5'(i)) ? alu.res : 8'h00)) | evt_s2_q;
        end
      end
    end else begin : g_plain
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          io_q[i] <= `BYAL_RST_BYTE;
        end else if (io_we && ioa_q[4:0] == 5'(i)) begin
          io_q[i] <= alu.res;
        end
      end
    end
  end

endmodule // byal_alu_top
`default_nettype wire

// File: design/byal_defines.svh
// Offsets, field positions, reset values and flag masks of the ALU block.
// Assumes inclusion by bare name from design files only.
`ifndef BYAL_DEFINES_SVH
`define BYAL_DEFINES_SVH

// Register byte offsets
`define BYAL_OFS_OPD 8'h00
`define BYAL_OFS_OPS 8'h04
`define BYAL_OFS_CMD 8'h08
`define BYAL_OFS_RES 8'h0C
`define BYAL_OFS_SREG 8'h10

// Command register fields
`define BYAL_CMD_OP_LSB 0
`define BYAL_CMD_BIT_LSB 8
`define BYAL_CMD_IOA_LSB 16

// Status register bit positions
`define BYAL_SREG_C 0
`define BYAL_SREG_Z 1
`define BYAL_SREG_ERR 9

// Flag update masks, bit order H S V N Z C
`define BYAL_UPD_ARITH 6'h2F
`define BYAL_UPD_LOGIC 6'h0E
`define BYAL_UPD_ONES 6'h0F
`define BYAL_UPD_WORD 6'h1F

// I/O space
`define BYAL_IO_BIT_MAX 6'h1F
`define BYAL_IO_EVT 8
`define BYAL_RST_BYTE 8'h00
`define BYAL_RST_WORD 16'h0000

`endif

// File: design/byal_pkg.sv
// Types shared by the ALU block.
// Assumes nothing of its surroundings.
`default_nettype none
package byal_pkg;

  typedef enum logic [4:0] {
    BYAL_CMD_ADD = 5'h00,
    BYAL_CMD_ADC = 5'h01,
    BYAL_CMD_SUB = 5'h02,
    BYAL_CMD_SBCR = 5'h03,
    BYAL_CMD_SUBK = 5'h04,
    BYAL_CMD_SBCK = 5'h05,
    BYAL_CMD_WADD = 5'h06,
    BYAL_CMD_WSUB = 5'h07,
    BYAL_CMD_AND = 5'h08,
    BYAL_CMD_ANDK = 5'h09,
    BYAL_CMD_OR = 5'h0A,
    BYAL_CMD_ORK = 5'h0B,
    BYAL_CMD_XOR = 5'h0C,
    BYAL_CMD_ONES = 5'h0D,
    BYAL_CMD_TWOS = 5'h0E,
    BYAL_CMD_BSET = 5'h0F,
    BYAL_CMD_BCLR = 5'h10,
    BYAL_CMD_IOSET = 5'h11,
    BYAL_CMD_IOCLR = 5'h12,
    BYAL_CMD_IOWR = 5'h13,
    BYAL_CMD_IORD = 5'h14
  } byal_cmd_t;

  typedef enum logic [2:0] {
    BYAL_OP_ADD, BYAL_OP_SUB, BYAL_OP_AND, BYAL_OP_OR,
    BYAL_OP_XOR, BYAL_OP_ONES, BYAL_OP_TWOS
  } byal_op_t;

  typedef enum logic [2:0] {
    BYAL_ST_IDLE = 3'b001,
    BYAL_ST_EXEC = 3'b010,
    BYAL_ST_WORD = 3'b100
  } byal_state_t;

endpackage
`default_nettype wire

// File: design/byal_alu_if.sv
// Operand and flag bundle between the control logic and the byte core.
// Assumes both ends run on the same clock and are purely combinational here.
`timescale 1ns/1ps
`default_nettype none
interface byal_alu_if;
  byal_pkg::byal_op_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic zin;
  logic [7:0] res;
  logic c;
  logic z;
  logic n;
  logic v;
  logic h;
  modport core (input op, a, b, cin, zin, output res, c, z, n, v, h);
  modport ctrl (output op, a, b, cin, zin, input res, c, z, n, v, h);
endinterface
`default_nettype wire

// File: design/byal_alu_core.sv
// Combinational 8-bit arithmetic and logic core with flag outputs.
// Assumes the caller masks which flags it keeps.
`timescale 1ns/1ps
`default_nettype none
module byal_alu_core (
  byal_alu_if.core alu
);
  logic [8:0] sum;
  logic [8:0] dif;
  logic [7:0] negated;

  always_comb begin
    sum = {1'b0, alu.a} + {1'b0, alu.b} + {8'h00, alu.cin};
    dif = {1'b0, alu.a} - {1'b0, alu.b} - {8'h00, alu.cin};
    negated = 8'h00 - alu.a;
    alu.res = 8'h00;
    alu.c = 1'b0;
    alu.h = 1'b0;
    alu.v = 1'b0;
    case (alu.op)
      byal_pkg::BYAL_OP_ADD: begin
        alu.res = sum[7:0];
        alu.c = sum[8];
        alu.h = (alu.a[3] & alu.b[3]) | (alu.b[3] & ~sum[3]) | (~sum[3] & alu.a[3]);
        alu.v = (alu.a[7] & alu.b[7] & ~sum[7]) | (~alu.a[7] & ~alu.b[7] & sum[7]);
      end
      byal_pkg::BYAL_OP_SUB: begin
        alu.res = dif[7:0];
        alu.c = (~alu.a[7] & alu.b[7]) | (alu.b[7] & dif[7]) | (dif[7] & ~alu.a[7]);
        alu.h = (~alu.a[3] & alu.b[3]) | (alu.b[3] & dif[3]) | (dif[3] & ~alu.a[3]);
        alu.v = (alu.a[7] & ~alu.b[7] & ~dif[7]) | (~alu.a[7] & alu.b[7] & dif[7]);
      end
      byal_pkg::BYAL_OP_AND: alu.res = alu.a & alu.b;
      byal_pkg::BYAL_OP_OR: alu.res = alu.a | alu.b;
      byal_pkg::BYAL_OP_XOR: alu.res = alu.a ^ alu.b;
      byal_pkg::BYAL_OP_ONES: begin
        alu.res = 8'hFF - alu.a;
        alu.c = 1'b1;
      end
      byal_pkg::BYAL_OP_TWOS: begin
        alu.res = negated;
        alu.c = (negated != 8'h00);
        alu.h = negated[3] | alu.a[3];
        alu.v = (negated == 8'h80);
      end
      default: alu.res = 8'h00;
    endcase
  end

  // Zero chains through zin so borrow forms keep an earlier nonzero
  assign alu.z = (alu.res == 8'h00) & alu.zin;
  assign alu.n = alu.res[7];
endmodule // byal_alu_core
`default_nettype wire

// File: testbench/byal_alu_props.sv
// Concurrent checks on the byte ALU top: busy length, stalls and flag side effects.
// Assumes one AHB master and hready_in tied to hreadyout_out.
`timescale 1ns/1ps
`default_nettype none
module byal_alu_props #(
  parameter int IO_DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [7:0] evt_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [5:0] flags_out,
  input wire logic busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic cmd_ph_q;
  logic sreg_ph_q;
  logic [4:0] op_q;
  wire logic take = hsel_in & htrans_in[1] & hready_in & hwrite_in;
  wire logic cmd_take = cmd_ph_q & hreadyout_out;
  wire logic sreg_take = sreg_ph_q & hreadyout_out;
  wire logic word_op = hwdata_in[4:0] == 5'h06 || hwdata_in[4:0] == 5'h07;
  // Write phases in flight; the command code is kept to judge the finished op
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_ph_q <= 1'b0;
      sreg_ph_q <= 1'b0;
    end else if (hready_in) begin
      cmd_ph_q <= take & (haddr_in[7:0] == 8'h08);
      sreg_ph_q <= take & (haddr_in[7:0] == 8'h10);
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) op_q <= 5'h00;
    else if (cmd_take) op_q <= hwdata_in[4:0];
  end
  a_byte_one_clk: assert property (
    cmd_take && !word_op |=> busy_out ##1 !busy_out) else $error("byte op busy length wrong");
  a_word_two_clk: assert property (
    cmd_take && word_op |=> busy_out [*2] ##1 !busy_out) else $error("word op busy length wrong");
  a_stall_busy: assert property (
    !hreadyout_out |-> busy_out ##[1:2] hreadyout_out) else $error("bus stalled while idle or too long");
  a_flags_cause: assert property (
    $changed(flags_out) |-> $past(busy_out) || $past(sreg_take)) else $error("flags moved without cause");
  a_ones_carry: assert property (
    $fell(busy_out) && op_q == 5'h0D |-> flags_out[0] && !flags_out[3]) else $error("ones complement C/V wrong");
  a_logic_clr_v: assert property (
    $fell(busy_out) && op_q inside {[5'h08:5'h0C], 5'h0F, 5'h10}
    |-> !flags_out[3] && flags_out[0] == $past(flags_out[0]) && flags_out[5] == $past(flags_out[5]))
    else $error("logic op flags wrong");
  a_byte_keep_s: assert property (
    $fell(busy_out) && !(op_q inside {5'h06, 5'h07}) |-> flags_out[4] == $past(flags_out[4]))
    else $error("byte op touched S");
  a_word_sign: assert property (
    $fell(busy_out) && op_q inside {5'h06, 5'h07}
    |-> flags_out[5] == $past(flags_out[5], 2) && flags_out[4] == (flags_out[3] ^ flags_out[2]))
    else $error("word op S/H wrong");
  cover property (cmd_take && word_op);
  cover property (!hreadyout_out);
  cover property ($fell(busy_out) && op_q == 5'h0D);
endmodule // byal_alu_props
bind byal_alu_top byal_alu_props #(.IO_DEPTH(IO_DEPTH)) u_props (.clk_in(clk_in), .rst_in(rst_in),
  .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
  .hwdata_in(hwdata_in), .hready_in(hready_in), .evt_in(evt_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .flags_out(flags_out), .busy_out(busy_out));
`default_nettype wire

// File: testbench/byal_ahb_master.sv
// AHB-Lite master standing in for the decoder: single word transfers only.
// Assumes one slave whose hreadyout comes back as hready_in.
`timescale 1ns/1ps
`default_nettype none
module byal_ahb_master (
  input wire logic clk_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  output logic hsel_out,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [2:0] hsize_out,
  output logic [31:0] hwdata_out
);
  initial begin
    hsel_out <= 1'b0;
    haddr_out <= 32'h0000_0000;
    htrans_out <= 2'b00;
    hwrite_out <= 1'b0;
    hsize_out <= 3'h2;
    hwdata_out <= 32'h0000_0000;
  end
  // Entered just after a rising edge; returns just after the edge ending the data phase
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel_out <= 1'b1;
    htrans_out <= 2'b10;
    hwrite_out <= wr;
    haddr_out <= {24'h00_0000, a};
    @(posedge clk_in);
    while (hready_in !== 1'b1) @(posedge clk_in);
    htrans_out <= 2'b00;
    hwdata_out <= wr ? d : ~hwdata_out;
    @(posedge clk_in);
    while (hready_in !== 1'b1) @(posedge clk_in);
    q = hrdata_in;
    // Stale write data must not look valid once the phase is over
    hwdata_out <= ~hwdata_out;
  endtask
endmodule // byal_ahb_master
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the byte ALU top over AHB-Lite.
// Assumes the AHB master model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] evt = 8'h00;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [5:0] flags;
  logic busy;
  logic [31:0] q;
  logic [15:0] r = 16'h0054;
  logic [15:0] d;
  logic [5:0] ef = 6'h00;
  int miscompares = 0;
  int checked = 0;
  always #5 clk_in = ~clk_in;
  byal_alu_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .evt_in(evt),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .flags_out(flags), .busy_out(busy));
  byal_ahb_master u_mst (.clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
    .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));
  // ----------------------------------------
  // Expectation helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Returns {H,S,V,N,Z,C, result}
  function automatic logic [21:0] calc(input logic [4:0] op, input logic [15:0] dv, input logic [7:0] k,
                                       input logic [5:0] f);
    logic [16:0] w;
    logic [8:0] t;
    logic [4:0] h;
    logic [7:0] a;
    logic [7:0] b;
    logic c;
    logic v;
    a = dv[7:0];
    b = k;
    c = f[0] & (op == 5'h01 || op == 5'h03 || op == 5'h05);
    if (op == 5'h06 || op == 5'h07) begin
      w = (op == 5'h06) ? dv + k : dv - k;
      v = (op == 5'h06) ? (!dv[15] && w[15]) : (dv[15] && !w[15]);
      return {f[5], w[15] ^ v, v, w[15], w[15:0] == 16'h0000, w[16], w[15:0]};
    end
    if (op >= 5'h08 && op != 5'h0E) begin
      case (op)
        5'h08, 5'h09: a = a & b;
        5'h0A, 5'h0B, 5'h0F: a = a | b;
        5'h0C: a = a ^ b;
        5'h0D: a = 8'hFF - a;
        default: a = a & (8'hFF - b);
      endcase
      return {f[5], f[4], 1'b0, a[7], a == 8'h00, f[0] | (op == 5'h0D), 8'h00, a};
    end
    if (op == 5'h0E) begin
      b = a;
      a = 8'h00;
    end
    t = (op <= 5'h01) ? a + b + c : a - b - c;
    h = (op <= 5'h01) ? a[3:0] + b[3:0] + c : a[3:0] - b[3:0] - c;
    v = (op <= 5'h01) ? (a[7] == b[7] && t[7] != a[7]) : (a[7] != b[7] && t[7] != a[7]);
    return {h[4], f[4], v, t[7], t[7:0] == 8'h00 && (f[1] || !(op == 5'h03 || op == 5'h05)), t[8], 8'h00, t[7:0]};
  endfunction
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    u_mst.xfer(1'b1, a, v, q);
  endtask
  task automatic rd(input logic [7:0] a);
    u_mst.xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic run(input logic [4:0] op, input logic [15:0] dv, input logic [7:0] k, input logic [5:0] f);
    logic [21:0] e;
    e = calc(op, dv, k, f);
    wr(8'h10, {26'h000_0000, f});
    wr(8'h00, {16'h0000, dv});
    wr(8'h04, {24'h00_0000, k});
    wr(8'h08, {27'h000_0000, op});
    rd(8'h0C);
    chk("result", {16'h0000, e[15:0]}, q);
    rd(8'h10);
    ef = e[21:16];
    chk("status", {26'h000_0000, ef}, q);
    chk("flags_out", {26'h000_0000, ef}, {26'h000_0000, flags});
    chk("busy_out", 32'h0000_0000, {31'h0000_0000, busy});
  endtask
  task automatic io(input logic [4:0] op, input logic [5:0] a, input logic [2:0] b, input logic [7:0] k);
    wr(8'h04, {24'h00_0000, k});
    wr(8'h08, {10'h000, a, 5'h00, b, 3'h0, op});
    rd(8'h0C);
  endtask
  task automatic finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_in);
    miscompares++;
    finish_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    for (int a = 0; a <= 16; a += 4) begin
      rd(8'(a));
      chk("reset value", 32'h0000_0000, q);
    end
    run(5'h00, 16'h00FF, 8'h01, 6'h00);
    run(5'h01, 16'h007F, 8'h00, 6'h01);
    run(5'h02, 16'h0080, 8'h01, 6'h00);
    run(5'h03, 16'h0000, 8'h00, 6'h03);
    run(5'h04, 16'h0010, 8'h01, 6'h00);
    run(5'h05, 16'h0001, 8'h00, 6'h03);
    run(5'h06, 16'hFFFF, 8'h01, 6'h20);
    run(5'h07, 16'h8000, 8'h01, 6'h00);
    run(5'h0F, 16'h0000, 8'h80, 6'h09);
    run(5'h10, 16'h00FF, 8'hFF, 6'h21);
    run(5'h0D, 16'h00FF, 8'h00, 6'h00);
    run(5'h0E, 16'h0080, 8'h00, 6'h00);
    for (int i = 0; i < 51; i++) begin
      r = lfsr(r);
      d = r;
      r = lfsr(r);
      run(5'(i % 17), d, r[7:0], r[13:8]);
    end
    evt <= 8'h05;
    repeat (4) @(posedge clk_in);
    evt <= 8'h00;
    io(5'h13, 6'h08, 3'h0, 8'h01);
    io(5'h14, 6'h08, 3'h0, 8'h00);
    chk("event write one", 32'h0000_0004, q);
    io(5'h11, 6'h08, 3'h5, 8'h00);
    chk("event bit set", 32'h0000_0024, q);
    io(5'h14, 6'h08, 3'h0, 8'h00);
    chk("event after set", 32'h0000_0000, q);
    io(5'h11, 6'h1F, 3'h7, 8'h00);
    io(5'h14, 6'h1F, 3'h0, 8'h00);
    chk("top io bit set", 32'h0000_0080, q);
    io(5'h12, 6'h1F, 3'h7, 8'h00);
    chk("top io bit clear", 32'h0000_0000, q);
    io(5'h11, 6'h20, 3'h0, 8'h00);
    rd(8'h10);
    chk("out of range bit op", {22'h00_0000, 4'h8, ef}, q);
    wr(8'h10, 32'h0000_0200);
    rd(8'h10);
    chk("error cleared", 32'h0000_0000, q);
    // Unused locations only ever see zeros
    wr(8'h14, 32'h0000_0000);
    rd(8'h14);
    chk("unmapped", 32'h0000_0000, q);
    chk("response", 32'h0000_0000, {31'h0000_0000, hresp});
    finish_test();
  end
endmodule // tb
`default_nettype wire
